// ===== gso_debounce.sv
// on-key debouncer with a selectable stability period
module gso_debounce #(
  parameter logic [22:0] SHORT_CYC = 23'(gso_pkg::DEB_SHORT_CYC),
  parameter logic [22:0] LONG_CYC = 23'(gso_pkg::DEB_LONG_CYC)
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset, high
  input wire logic rawIn, // raw key level
  input wire logic longSel, // 1 selects long period
  output logic level // debounced level
);
  typedef struct packed {
    logic level;
    logic [22:0] cnt;
  } gso_deb_state_type;

  gso_deb_state_type st;
  gso_deb_state_type next_st;
  logic [22:0] limit;

  assign limit = longSel ? LONG_CYC : SHORT_CYC;

  always_comb begin
    next_st = st;
    if (rawIn == st.level) begin
      next_st.cnt = 23'h000000;
    end else if (st.cnt >= limit - 23'h000001) begin
      next_st.level = rawIn;
      next_st.cnt = 23'h000000;
    end else begin
      next_st.cnt = st.cnt + 23'h000001;
    end
  end

  // released key reads high through the pullup
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= '{level: 1'b1, cnt: 23'h000000};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

  a_deb_stable_full: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(st.level) |-> ($past(st.cnt) >= $past(limit) - 23'h000001 && $past(rawIn) == st.level))
    else $error("debounced level changed before the period elapsed");

  a_deb_restart: assert property (@(posedge clk_sys) disable iff (reset)
    (rawIn == st.level) |=> (st.cnt == 23'h000000))
    else $error("debounce count not restarted on input match");
endmodule : gso_debounce

// ===== gso_host_model.sv
// behavioural on-key contact and open-drain pull-ups facing the supervisor
module gso_host_model (
  input wire logic clk_sys, // system clock
  input wire logic keyCmd, // key level asked for by the scenario
  input wire logic irqOutNOut, // interrupt drive value
  input wire logic irqOutNOeN, // interrupt enable, low drives
  input wire logic rstOut, // reset drive value
  input wire logic rstOeN, // reset enable, low drives
  output logic onKeyN, // contact level after bounce
  output logic irqPin, // resolved interrupt wire
  output logic rstPin // resolved reset wire
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastCmd = 1'b1;
  logic [1:0] chatter = 2'h0;
  initial onKeyN = 1'b1;
  // external pull-ups win unless the pin is driven
  assign irqPin = irqOutNOeN ? 1'b1 : irqOutNOut;
  assign rstPin = rstOeN ? 1'b1 : rstOut;
  // a real contact chatters after every move, so short presses never settle
  always @(posedge clk_sys) begin
    if (keyCmd !== lastCmd) begin
      lastCmd <= keyCmd;
      chatter <= 2'h2;
    end else if (chatter != 2'h0) begin
      chatter <= chatter - 2'h1;
    end
    onKeyN <= (keyCmd !== lastCmd || chatter != 2'h0) ? ~onKeyN : keyCmd;
  end
endmodule : gso_host_model

// ===== gso_pkg.sv
// constants, encodings and carriers shared by the global supervisor block
package gso_pkg;
  // clock and timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned DEB_SHORT_US = 500;
  localparam int unsigned DEB_LONG_MS = 30;
  localparam int unsigned MRST_SHORT_S = 4;
  localparam int unsigned MRST_LONG_S = 8;
  localparam int unsigned RST_RELEASE_NS = 1000;
  localparam int unsigned RST_LEAD_NS = 1000;
  localparam int unsigned SEQ_STEP_NS = 1000;
  localparam int unsigned DEB_SHORT_CYC = DEB_SHORT_US * CLK_MHZ;
  localparam int unsigned DEB_LONG_CYC = DEB_LONG_MS * 1000 * CLK_MHZ;
  localparam int unsigned MRST_SHORT_CYC = MRST_SHORT_S * 1000000 * CLK_MHZ;
  localparam int unsigned MRST_LONG_CYC = MRST_LONG_S * 1000000 * CLK_MHZ;
  localparam int unsigned RST_RELEASE_CYC = (RST_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_LEAD_CYC = (RST_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEQ_STEP_CYC = (SEQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEB_CNT_W = 23;
  localparam int unsigned HOLD_CNT_W = 31;
  localparam int unsigned STEP_CNT_W = 16;
  // register offsets
  localparam logic [7:0] OFS_ERC = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_ID = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  // global_config_zero fields
  localparam int unsigned CFG_STYLE_LSB = 0;
  localparam int unsigned CFG_DEB_BIT = 2;
  localparam int unsigned CFG_PU_BIT = 3;
  localparam int unsigned CFG_MRST_BIT = 4;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'h1f;
  // global_irq_flags bits
  localparam int unsigned FLG_KEY_FALL = 0;
  localparam int unsigned FLG_KEY_RISE = 1;
  localparam int unsigned FLG_ALM1 = 2;
  localparam int unsigned FLG_ALM2 = 3;
  localparam int unsigned NFLAGS = 4;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'hf;
  // event_record_register bits
  localparam int unsigned ERC_TSD = 0;
  localparam int unsigned ERC_UVLO = 1;
  localparam int unsigned ERC_OVLO = 2;
  localparam int unsigned ERC_MRST = 3;
  localparam logic [3:0] ERC_RESET = 4'h0;
  // status bits
  localparam int unsigned STS_KEY = 0;
  localparam int unsigned STS_ALM1 = 1;
  localparam int unsigned STS_ALM2 = 2;
  localparam int unsigned STS_UVLO = 3;
  localparam int unsigned STS_OVLO = 4;
  localparam int unsigned STS_IRQ_PIN = 5;
  localparam int unsigned STS_RST_PIN = 6;

  typedef enum logic [1:0] {
    STYLE_BUTTON = 2'b00,
    STYLE_SLIDE = 2'b01,
    STYLE_LOGIC = 2'b10
  } gso_style_type;

  typedef enum logic [2:0] {
    SEQ_SHUTDOWN = 3'b000,
    SEQ_STANDBY = 3'b001,
    SEQ_POWER_UP = 3'b010,
    SEQ_RST_RELEASE = 3'b011,
    SEQ_ON = 3'b100,
    SEQ_RST_LEAD = 3'b101,
    SEQ_POWER_DOWN = 3'b110
  } gso_seq_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gso_bus_req_type;

  typedef struct packed {
    logic undervolt;
    logic overvolt;
    logic alarmLow;
    logic alarmHigh;
    logic thermShut;
  } gso_monitor_type;
endpackage : gso_pkg

// ===== gso_supervisor.sv
// global supervisor: monitors, on-key, interrupt line and reset sequencing
// Notes on behaviour
// - the reset input holds every register at its defined value until released
// - undervoltage input is passed out as a flag and recorded
// - overvoltage forces all regulators off and raises the inhibit output
// - two thermal alarms each have a status bit and maskable rising flag
// - thermal shutdown records its event and switches everything off at once
// - thermal shutdown record survives shutdown; cleared only by software or reset
// - a readable identifier register names the option set
// - on-key is debounced with short or long period chosen by software
// - debounced key rising and falling edges set separate maskable flags
// - style field: 00 push-button, 01 slide-switch, 10 logic
// - push-button and slide-switch styles power up on a debounced falling edge
// - push-button style, key low for hold time in on state, power down to shutdown
// - slide-switch style, key high for hold time in on state, power down to standby
// - logic style powers up while key low, powers down to shutdown when high
// - style resets to push-button; host rewrites it before hold time expires
// - pullup weak bit 0 selects strong pullup, 1 very weak pullup
// - interrupt pin is driven low while any unmasked flag is set
// - all masks reset to masked; a masked flag never moves the pin
// - reset output releases after the last regulator plus release delay
// - reset output asserts a lead time before any regulator turns off, except on faults
// - resistor variant follows three enable pins directly per output
module gso_supervisor #(
  parameter logic [22:0] DEB_SHORT_CYC = 23'(gso_pkg::DEB_SHORT_CYC),
  parameter logic [22:0] DEB_LONG_CYC = 23'(gso_pkg::DEB_LONG_CYC),
  parameter logic [30:0] MRST_SHORT_CYC = 31'(gso_pkg::MRST_SHORT_CYC),
  parameter logic [30:0] MRST_LONG_CYC = 31'(gso_pkg::MRST_LONG_CYC),
  parameter logic [15:0] SEQ_STEP_CYC = 16'(gso_pkg::SEQ_STEP_CYC),
  parameter logic [15:0] RST_RELEASE_CYC = 16'(gso_pkg::RST_RELEASE_CYC),
  parameter logic [15:0] RST_LEAD_CYC = 16'(gso_pkg::RST_LEAD_CYC),
  // arbitrary value, replaced per option set
  parameter logic [7:0] OPTION_ID = 8'h5a,
  parameter bit RESISTOR_VARIANT = 1'b0
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // supply reset, async, high
  input gso_pkg::gso_bus_req_type busReq, // register access
  output logic [7:0] rdData, // read data, cycle after read
  input gso_pkg::gso_monitor_type monitor, // comparator outputs
  input wire logic onKeyN, // on-key, low active
  input wire logic [2:0] enPin, // per-output enables, variant only
  output logic [2:0] regOn, // regulator enables
  output logic regInhibit, // overvoltage lockout
  output logic supplyUndervoltFlag, // to on/off controller
  output logic onkeyPullupWeak, // 1 selects weak pullup
  input wire logic irqOutNIn, // interrupt pin level
  output logic irqOutNOut, // interrupt pin drive value
  output logic irqOutNOeN, // interrupt pin enable, low drives
  input wire logic sysResetOutNIn, // reset pin level
  output logic sysResetOutNOut, // reset pin drive value
  output logic sysResetOutNOeN // reset pin enable, low drives
);
  typedef struct packed {
    gso_pkg::gso_seq_type seq;
    logic [1:0] step;
    logic [15:0] seqCnt;
    logic [30:0] holdCnt;
    logic toStandby;
    logic [7:0] cfg;
    logic [3:0] flags;
    logic [3:0] mask;
    logic [3:0] erc;
    logic keyPrev;
    logic alm1Prev;
    logic alm2Prev;
    logic [2:0] regOn;
    logic irqOeN;
    logic rstOeN;
    logic uvFlag;
    logic inhibit;
    logic pullupWeak;
    logic [7:0] rdata;
  } gso_state_type;

  gso_state_type st;
  gso_state_type next_st;
  gso_pkg::gso_style_type style;
  logic keyDeb;
  logic keyFell;
  logic keyRose;
  logic holdCond;
  logic holdExpire;
  logic wake;
  logic fault;
  logic [30:0] mrstLimit;
  logic [3:0] flagSet;
  logic [3:0] ercSet;
  logic [3:0] flagClr;
  logic [3:0] ercClr;
  logic [7:0] status;

  gso_debounce #(
    .SHORT_CYC(DEB_SHORT_CYC),
    .LONG_CYC(DEB_LONG_CYC)
  ) u_key_deb (
    .clk_sys(clk_sys),
    .reset(reset),
    .rawIn(onKeyN),
    .longSel(st.cfg[gso_pkg::CFG_DEB_BIT]),
    .level(keyDeb)
  );

  assign style = gso_pkg::gso_style_type'(st.cfg[gso_pkg::CFG_STYLE_LSB +: 2]);
  assign mrstLimit = st.cfg[gso_pkg::CFG_MRST_BIT] ? MRST_LONG_CYC : MRST_SHORT_CYC;
  assign keyFell = st.keyPrev & ~keyDeb;
  assign keyRose = ~st.keyPrev & keyDeb;
  assign wake = (style == gso_pkg::STYLE_LOGIC) ? ~keyDeb : keyFell;
  // slide holds high; other styles hold low
  assign holdCond = (style == gso_pkg::STYLE_SLIDE) ? keyDeb : ~keyDeb;
  assign holdExpire = (st.seq == gso_pkg::SEQ_ON) && (style != gso_pkg::STYLE_LOGIC)
    && holdCond && (st.holdCnt >= mrstLimit - 31'h00000001);
  assign fault = monitor.thermShut | monitor.overvolt;

  // key edge flags, alarm rising flags
  assign flagSet[gso_pkg::FLG_KEY_FALL] = keyFell;
  assign flagSet[gso_pkg::FLG_KEY_RISE] = keyRose;
  assign flagSet[gso_pkg::FLG_ALM1] = monitor.alarmLow & ~st.alm1Prev;
  assign flagSet[gso_pkg::FLG_ALM2] = monitor.alarmHigh & ~st.alm2Prev;
  assign ercSet[gso_pkg::ERC_TSD] = monitor.thermShut;
  assign ercSet[gso_pkg::ERC_UVLO] = monitor.undervolt;
  assign ercSet[gso_pkg::ERC_OVLO] = monitor.overvolt;
  assign ercSet[gso_pkg::ERC_MRST] = holdExpire;

  assign flagClr = (busReq.wr && busReq.addr == gso_pkg::OFS_FLAGS) ? busReq.wdata[3:0] : 4'h0;
  assign ercClr = (busReq.wr && busReq.addr == gso_pkg::OFS_ERC) ? busReq.wdata[3:0] : 4'h0;

  always_comb begin
    status = 8'h00;
    status[gso_pkg::STS_KEY] = keyDeb;
    status[gso_pkg::STS_ALM1] = monitor.alarmLow;
    status[gso_pkg::STS_ALM2] = monitor.alarmHigh;
    status[gso_pkg::STS_UVLO] = monitor.undervolt;
    status[gso_pkg::STS_OVLO] = monitor.overvolt;
    status[gso_pkg::STS_IRQ_PIN] = irqOutNIn;
    status[gso_pkg::STS_RST_PIN] = sysResetOutNIn;
  end

  always_comb begin
    next_st = st;
    next_st.keyPrev = keyDeb;
    next_st.alm1Prev = monitor.alarmLow;
    next_st.alm2Prev = monitor.alarmHigh;
    next_st.uvFlag = monitor.undervolt;
    next_st.inhibit = monitor.overvolt;
    // set wins over a same-cycle clear
    next_st.flags = (st.flags & ~flagClr) | flagSet;
    next_st.erc = (st.erc & ~ercClr) | ercSet;
    if (busReq.wr && busReq.addr == gso_pkg::OFS_MASK) begin
      next_st.mask = busReq.wdata[3:0];
    end
    if (busReq.wr && busReq.addr == gso_pkg::OFS_CFG) begin
      next_st.cfg = busReq.wdata & gso_pkg::CFG_WMASK;
    end
    next_st.pullupWeak = next_st.cfg[gso_pkg::CFG_PU_BIT];

    next_st.rdata = 8'h00;
    if (busReq.rd) begin
      if (busReq.addr == gso_pkg::OFS_ERC) begin
        next_st.rdata = {4'h0, st.erc};
      end else if (busReq.addr == gso_pkg::OFS_FLAGS) begin
        next_st.rdata = {4'h0, st.flags};
      end else if (busReq.addr == gso_pkg::OFS_MASK) begin
        next_st.rdata = {4'h0, st.mask};
      end else if (busReq.addr == gso_pkg::OFS_STATUS) begin
        next_st.rdata = status;
      end else if (busReq.addr == gso_pkg::OFS_CFG) begin
        next_st.rdata = st.cfg;
      end else if (busReq.addr == gso_pkg::OFS_ID) begin
        next_st.rdata = OPTION_ID;
      end else if (busReq.addr == gso_pkg::OFS_STATE) begin
        next_st.rdata = {2'h0, st.regOn, st.seq};
      end else begin
        next_st.rdata = 8'h00;
      end
    end

    case (st.seq)
      gso_pkg::SEQ_SHUTDOWN, gso_pkg::SEQ_STANDBY: begin
        if (wake && !fault && !monitor.undervolt) begin
          next_st.seq = gso_pkg::SEQ_POWER_UP;
          next_st.step = 2'h0;
          next_st.seqCnt = 16'h0000;
        end
      end
      gso_pkg::SEQ_POWER_UP: begin
        next_st.seqCnt = st.seqCnt + 16'h0001;
        if (st.seqCnt >= SEQ_STEP_CYC - 16'h0001) begin
          next_st.regOn[st.step] = 1'b1;
          next_st.seqCnt = 16'h0000;
          if (st.step == 2'h2) begin
            next_st.seq = gso_pkg::SEQ_RST_RELEASE;
          end else begin
            next_st.step = st.step + 2'h1;
          end
        end
      end
      gso_pkg::SEQ_RST_RELEASE: begin
        next_st.seqCnt = st.seqCnt + 16'h0001;
        if (st.seqCnt >= RST_RELEASE_CYC - 16'h0001) begin
          next_st.rstOeN = 1'b1;
          next_st.seq = gso_pkg::SEQ_ON;
          next_st.holdCnt = 31'h00000000;
        end
      end
      gso_pkg::SEQ_ON: begin
        next_st.holdCnt = holdCond ? st.holdCnt + 31'h00000001 : 31'h00000000;
        if (holdExpire || monitor.undervolt
            || (style == gso_pkg::STYLE_LOGIC && keyDeb)) begin
          next_st.toStandby = holdExpire && (style == gso_pkg::STYLE_SLIDE)
            && !monitor.undervolt;
          next_st.seq = gso_pkg::SEQ_RST_LEAD;
          next_st.seqCnt = 16'h0000;
          next_st.rstOeN = 1'b0;
        end
      end
      gso_pkg::SEQ_RST_LEAD: begin
        next_st.seqCnt = st.seqCnt + 16'h0001;
        if (st.seqCnt >= RST_LEAD_CYC - 16'h0001) begin
          next_st.seq = gso_pkg::SEQ_POWER_DOWN;
          next_st.step = 2'h2;
          next_st.seqCnt = 16'h0000;
        end
      end
      gso_pkg::SEQ_POWER_DOWN: begin
        next_st.seqCnt = st.seqCnt + 16'h0001;
        if (st.seqCnt >= SEQ_STEP_CYC - 16'h0001) begin
          next_st.regOn[st.step] = 1'b0;
          next_st.seqCnt = 16'h0000;
          if (st.step == 2'h0) begin
            next_st.seq = st.toStandby ? gso_pkg::SEQ_STANDBY : gso_pkg::SEQ_SHUTDOWN;
          end else begin
            next_st.step = st.step - 2'h1;
          end
        end
      end
      default: begin
        next_st.seq = gso_pkg::SEQ_SHUTDOWN;
      end
    endcase

    // overvoltage lockout, thermal shutdown; no sequencing on faults
    if (fault) begin
      next_st.seq = gso_pkg::SEQ_SHUTDOWN;
      next_st.regOn = 3'h0;
      next_st.rstOeN = 1'b0;
      next_st.seqCnt = 16'h0000;
    end
    // pin-driven outputs in the resistor variant
    if (RESISTOR_VARIANT) begin
      next_st.regOn = enPin & {3{~fault}};
    end
    // NOR of unmasked flags, masked bits ignored
    next_st.irqOeN = ~|(next_st.flags & ~next_st.mask);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= '{seq: gso_pkg::SEQ_SHUTDOWN, step: 2'h0, seqCnt: 16'h0000,
        holdCnt: 31'h00000000, toStandby: 1'b0,
        cfg: gso_pkg::CFG_RESET, flags: gso_pkg::FLAGS_RESET,
        mask: gso_pkg::MASK_RESET, erc: gso_pkg::ERC_RESET,
        keyPrev: 1'b1, alm1Prev: 1'b0, alm2Prev: 1'b0, regOn: 3'h0,
        irqOeN: 1'b1, rstOeN: 1'b0, uvFlag: 1'b0, inhibit: 1'b0,
        pullupWeak: 1'b0, rdata: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  // open-drain pins only ever pull low; the enable carries the state
  assign irqOutNOut = 1'b0;
  assign sysResetOutNOut = 1'b0;
  assign irqOutNOeN = st.irqOeN;
  assign sysResetOutNOeN = st.rstOeN;
  assign regOn = st.regOn;
  assign regInhibit = st.inhibit;
  assign supplyUndervoltFlag = st.uvFlag;
  assign onkeyPullupWeak = st.pullupWeak;
  assign rdData = st.rdata;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_logic_wake;
    (st.seq == gso_pkg::SEQ_SHUTDOWN || st.seq == gso_pkg::SEQ_STANDBY)
      && style == gso_pkg::STYLE_LOGIC && !keyDeb && !fault && !monitor.undervolt;
  endsequence

  sequence s_hold_done;
    st.seq == gso_pkg::SEQ_ON && style == gso_pkg::STYLE_BUTTON && !keyDeb
      && st.holdCnt >= mrstLimit - 31'h00000001 && !fault;
  endsequence

  a_irq_unmasked_low: assert property (
    (st.flags[gso_pkg::FLG_KEY_FALL] && !st.mask[gso_pkg::FLG_KEY_FALL]) |-> !irqOutNOeN)
    else $error("unmasked flag set but interrupt pin released");
  a_irq_masked_idle: assert property (
    (&st.mask) |-> irqOutNOeN)
    else $error("interrupt pin driven while all flags masked");
  a_key_fall_flag: assert property (
    keyFell |=> st.flags[gso_pkg::FLG_KEY_FALL])
    else $error("key falling edge flag not set");
  a_key_rise_flag: assert property (
    keyRose |=> st.flags[gso_pkg::FLG_KEY_RISE])
    else $error("key rising edge flag not set");
  a_alarm_high_flag: assert property (
    (monitor.alarmHigh && !st.alm2Prev) |=> st.flags[gso_pkg::FLG_ALM2])
    else $error("high alarm rising flag not set");
  a_tsd_turn_off: assert property (
    monitor.thermShut |=> (regOn == 3'h0 && st.erc[gso_pkg::ERC_TSD] && !sysResetOutNOeN))
    else $error("thermal shutdown did not switch off and record");
  a_ovlo_inhibit: assert property (
    monitor.overvolt |=> (regOn == 3'h0 && regInhibit))
    else $error("overvoltage did not inhibit regulators");
  a_uvlo_flag_out: assert property (
    monitor.undervolt |=> (supplyUndervoltFlag && st.erc[gso_pkg::ERC_UVLO]))
    else $error("undervoltage not flagged");
  a_reset_lead_down: assert property (
    (st.seq == gso_pkg::SEQ_RST_LEAD || st.seq == gso_pkg::SEQ_POWER_DOWN)
      |-> !sysResetOutNOeN)
    else $error("reset output released while powering down");
  a_release_after_last: assert property (
    (!RESISTOR_VARIANT && $rose(sysResetOutNOeN))
      |-> (regOn == 3'h7 && $past(st.seq) == gso_pkg::SEQ_RST_RELEASE))
    else $error("reset output released before last regulator");
  a_logic_power_up: assert property (
    s_logic_wake |=> st.seq == gso_pkg::SEQ_POWER_UP)
    else $error("logic style low level did not start power-up");
  a_button_hold_down: assert property (
    s_hold_done |=> (st.seq == gso_pkg::SEQ_RST_LEAD && st.erc[gso_pkg::ERC_MRST]
      && !st.toStandby))
    else $error("push-button hold did not start power-down");
endmodule : gso_supervisor

// ===== tb_top.sv
// self-checking bench for the global supervisor block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] OPT_ID = 8'h3c; // arbitrary option code
  localparam logic [15:0] STEP_CYC = 16'h2;
  localparam logic [15:0] REL_CYC = 16'h3;
  localparam logic [15:0] LEAD_CYC = 16'h3;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } gso_row_type;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic keyCmd = 1'b1;
  gso_pkg::gso_bus_req_type busReq = '0;
  gso_pkg::gso_monitor_type mon = '0;
  logic [7:0] rdData, v;
  logic [2:0] regOn, regOnV;
  logic [2:0] enPin = 3'h5;
  logic regInhibit, supplyUndervoltFlag, onkeyPullupWeak, onKeyN, irqPin, rstPin;
  logic irqOutNOut, irqOutNOeN, sysResetOutNOut, sysResetOutNOeN;
  int nMismatch = 0;
  int nTests = 0;
  gso_row_type rows [9] = '{'{1'b0, gso_pkg::OFS_MASK, 8'h00, 8'h0f},
    '{1'b0, gso_pkg::OFS_CFG, 8'h00, 8'h00}, '{1'b0, gso_pkg::OFS_ID, 8'h00, OPT_ID},
    '{1'b0, gso_pkg::OFS_STATUS, 8'h00, 8'h21}, '{1'b0, gso_pkg::OFS_ERC, 8'h00, 8'h00},
    '{1'b0, 8'h20, 8'h00, 8'h00}, '{1'b1, gso_pkg::OFS_CFG, 8'hff, 8'h1f},
    '{1'b1, gso_pkg::OFS_ID, 8'h00, OPT_ID}, '{1'b1, gso_pkg::OFS_CFG, 8'h00, 8'h00}};

  always #2.5 clk_sys = ~clk_sys;

  gso_supervisor #(.DEB_SHORT_CYC(23'h4), .DEB_LONG_CYC(23'h8), .MRST_SHORT_CYC(31'h14),
    .MRST_LONG_CYC(31'h28), .SEQ_STEP_CYC(STEP_CYC), .RST_RELEASE_CYC(REL_CYC),
    .RST_LEAD_CYC(LEAD_CYC), .OPTION_ID(OPT_ID)) i_gso_supervisor (
    .clk_sys(clk_sys), .reset(reset), .busReq(busReq), .rdData(rdData), .monitor(mon),
    .onKeyN(onKeyN), .enPin(enPin), .regOn(regOn), .regInhibit(regInhibit),
    .supplyUndervoltFlag(supplyUndervoltFlag), .onkeyPullupWeak(onkeyPullupWeak),
    .irqOutNIn(irqPin), .irqOutNOut(irqOutNOut), .irqOutNOeN(irqOutNOeN),
    .sysResetOutNIn(rstPin), .sysResetOutNOut(sysResetOutNOut),
    .sysResetOutNOeN(sysResetOutNOeN));
  gso_host_model i_gso_host_model (.clk_sys(clk_sys), .keyCmd(keyCmd),
    .irqOutNOut(irqOutNOut), .irqOutNOeN(irqOutNOeN), .rstOut(sysResetOutNOut),
    .rstOeN(sysResetOutNOeN), .onKeyN(onKeyN), .irqPin(irqPin), .rstPin(rstPin));
  // resistor variant: only its pin-following outputs are watched
  gso_supervisor #(.RESISTOR_VARIANT(1'b1)) i_gso_supervisor_res (.clk_sys(clk_sys),
    .reset(reset), .busReq(busReq), .rdData(), .monitor(mon), .onKeyN(onKeyN), .enPin(enPin),
    .regOn(regOnV), .regInhibit(), .supplyUndervoltFlag(), .onkeyPullupWeak(),
    .irqOutNIn(irqPin), .irqOutNOut(), .irqOutNOeN(), .sysResetOutNIn(rstPin),
    .sysResetOutNOut(), .sysResetOutNOeN());

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask : tick
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq <= '0;
    #1;
  endtask : wrReg
  task automatic chkVal(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED t=%0t value %h want %h", $time, got, exp);
    end
  endtask : chkVal
  task automatic chkPin(input logic got, input logic exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED t=%0t pin %b want %b", $time, got, exp);
    end
  endtask : chkPin
  // read data stand only in the cycle after the strobe
  task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq <= '0;
    #1;
    v = rdData;
    chkVal(v, exp);
  endtask : chkReg
  task automatic waitRst(input logic lvl);
    for (int j = 0; j < 150 && sysResetOutNOeN !== lvl; j++) tick(1);
    chkPin(sysResetOutNOeN, lvl);
  endtask : waitRst
  task automatic waitOff;
    for (int j = 0; j < 150 && regOn !== 3'h0; j++) tick(1);
    chkVal({5'h0, regOn}, 8'h00);
  endtask : waitOff
  task automatic keyTo(input logic lvl, input int n);
    @(posedge clk_sys);
    keyCmd <= lvl;
    #1;
    tick(n);
  endtask : keyTo
  task automatic powerUp;
    keyTo(1'b1, 14);
    keyTo(1'b0, 0);
    waitRst(1'b1);
    chkVal({5'h0, regOn}, 8'h07);
    chkReg(gso_pkg::OFS_STATE, 8'h3c);
  endtask : powerUp
  task automatic closeOut;
    if (nMismatch == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : closeOut

  initial begin
    #100000;
    nMismatch++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    closeOut();
  end

  initial begin
    tick(6);
    chkPin(irqOutNOeN, 1'b1);
    chkPin(sysResetOutNOeN, 1'b0);
    chkVal({5'h0, regOn}, 8'h00);
    chkVal({5'h0, regOnV}, 8'h00);
    @(posedge clk_sys);
    reset <= 1'b0;
    tick(8);
    chkVal({5'h0, regOnV}, 8'h05);
    foreach (rows[i]) begin
      if (rows[i].wr) wrReg(rows[i].addr, rows[i].wdata);
      chkReg(rows[i].addr, rows[i].exp);
    end
    wrReg(gso_pkg::OFS_CFG, 8'h08);
    chkPin(onkeyPullupWeak, 1'b1);
    wrReg(gso_pkg::OFS_CFG, 8'h00);
    chkPin(onkeyPullupWeak, 1'b0);
    // a press shorter than the debounce period must be ignored
    keyTo(1'b0, 2);
    keyTo(1'b1, 12);
    chkReg(gso_pkg::OFS_FLAGS, 8'h00);
    chkReg(gso_pkg::OFS_STATE, 8'h00);
    powerUp();
    chkReg(gso_pkg::OFS_FLAGS, 8'h01);
    chkPin(irqOutNOeN, 1'b1);
    wrReg(gso_pkg::OFS_MASK, 8'h0e);
    chkPin(irqOutNOeN, 1'b0);
    wrReg(gso_pkg::OFS_FLAGS, 8'h01);
    chkPin(irqOutNOeN, 1'b1);
    // key kept low in the on state: manual reset
    waitRst(1'b0);
    chkVal({5'h0, regOn}, 8'h07);
    waitOff();
    chkReg(gso_pkg::OFS_STATE, 8'h00);
    chkReg(gso_pkg::OFS_ERC, 8'h08);
    wrReg(gso_pkg::OFS_MASK, 8'h03);
    @(posedge clk_sys);
    mon.alarmLow <= 1'b1;
    tick(3);
    chkReg(gso_pkg::OFS_STATUS, 8'h02);
    chkVal(v & 8'h06, 8'h02);
    chkReg(gso_pkg::OFS_FLAGS, 8'h04);
    chkPin(irqPin, 1'b0);
    wrReg(gso_pkg::OFS_FLAGS, 8'h04);
    chkPin(irqOutNOeN, 1'b1);
    @(posedge clk_sys);
    mon.alarmHigh <= 1'b1;
    tick(3);
    chkReg(gso_pkg::OFS_FLAGS, 8'h08);
    chkPin(irqOutNOeN, 1'b0);
    wrReg(gso_pkg::OFS_MASK, 8'h0f);
    chkPin(irqOutNOeN, 1'b1);
    @(posedge clk_sys);
    mon <= '0;
    wrReg(gso_pkg::OFS_FLAGS, 8'hff);
    powerUp();
    @(posedge clk_sys);
    mon.thermShut <= 1'b1;
    tick(2);
    chkVal({5'h0, regOn}, 8'h00);
    chkPin(sysResetOutNOeN, 1'b0);
    @(posedge clk_sys);
    mon.thermShut <= 1'b0;
    tick(4);
    chkReg(gso_pkg::OFS_ERC, 8'h09);
    @(posedge clk_sys);
    mon.overvolt <= 1'b1;
    mon.undervolt <= 1'b1;
    tick(2);
    chkPin(regInhibit, 1'b1);
    chkPin(supplyUndervoltFlag, 1'b1);
    chkVal({5'h0, regOnV}, 8'h00);
    keyTo(1'b1, 14);
    keyTo(1'b0, 20);
    chkReg(gso_pkg::OFS_STATE, 8'h00);
    @(posedge clk_sys);
    mon <= '0;
    enPin <= 3'h2;
    tick(2);
    chkPin(regInhibit, 1'b0);
    chkVal({5'h0, regOnV}, 8'h02);
    wrReg(gso_pkg::OFS_CFG, 8'h01);
    powerUp();
    keyTo(1'b1, 0);
    waitRst(1'b0);
    waitOff();
    chkReg(gso_pkg::OFS_STATE, 8'h01);
    wrReg(gso_pkg::OFS_CFG, 8'h02);
    keyTo(1'b0, 0);
    waitRst(1'b1);
    chkReg(gso_pkg::OFS_STATE, 8'h3c);
    keyTo(1'b1, 0);
    waitOff();
    chkReg(gso_pkg::OFS_STATE, 8'h00);
    wrReg(gso_pkg::OFS_CFG, 8'h14);
    wrReg(gso_pkg::OFS_FLAGS, 8'hff);
    keyTo(1'b0, 6);
    keyTo(1'b1, 20);
    chkReg(gso_pkg::OFS_FLAGS, 8'h00);
    powerUp();
    // long hold selected: still on where the short hold would have expired
    tick(25);
    chkReg(gso_pkg::OFS_STATE, 8'h3c);
    waitRst(1'b0);
    closeOut();
  end
endmodule : tb_top
